// File: charge_time_map.svh
`ifndef CHARGE_TIME_MAP_SVH
`define CHARGE_TIME_MAP_SVH

// register offset (byte address on the plain port)
`define MUC_CONTROL_OFFSET      8'h00
`define MUC_STATUS_OFFSET       8'h04
`define MUC_RESET_VALUE         32'h0000_0000
`define MUC_WRITE_MASK          32'h0000_ffff

// field positions in the control word
`define MUC_TIME_GEN_BIT        12
`define MUC_EDGE_GATE_BIT       11
`define MUC_SEQEN_BIT           10
`define MUC_DISCH_BIT           9
`define MUC_TRIG_BIT            8
`define MUC_TRIM_LSB            2
`define MUC_TRIM_MSB            7
`define MUC_RANGE_LSB           0
`define MUC_RANGE_MSB           1
`define MUC_EDGE2_SEL_LSB       16
`define MUC_EDGE2_SEL_MSB       19

// second-edge selection that picks the first comparator output
`define MUC_EDGE2_SEL_COMP1     4'hd

// converter sampling minimums for temperature measurement
`define MUC_CLK_PERIOD_NS       10
`define MUC_SAMPLE_X10_NS       1600
`define MUC_SAMPLE_X100_NS      300

`endif

// File: charge_time_pkg.sv
package charge_time_pkg;

    typedef enum logic [1:0] {
        RANGE_X1000 = 2'b00,
        RANGE_X1    = 2'b01,
        RANGE_X10   = 2'b10,
        RANGE_X100  = 2'b11
    } current_range_t;

    typedef struct packed {
        logic            time_generation_enable;
        logic            edge_gate_enable;
        logic            edge_order_enable;
        logic            source_discharge_enable;
        logic            trigger_output_enable;
        logic signed [5:0] current_trim;
        current_range_t  current_range_select;
    } control_fields_t;

    typedef struct packed {
        logic [2:0] range_onehot;   // x1, x10, x100
        logic       range_x1000;
    } range_decode_t;

    typedef enum logic [1:0] {
        EDGE_IDLE  = 2'b00,
        EDGE_FIRST = 2'b01,
        EDGE_BOTH  = 2'b11
    } edge_state_t;

endpackage

// File: charge_time_edge_control.sv
`include "charge_time_map.svh"
`timescale 1ns/1ns
`default_nettype none

module charge_time_edge_control #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [31:0]       rdata_o,
    input  wire logic              edge1_i,
    input  wire logic              edge2_i,
    input  wire logic              sample_active_i,
    output logic                   edge1_o,
    output logic                   edge2_o,
    output logic                   delay_gen_en_o,
    output logic                   source_ground_o,
    output logic                   trigger_o,
    output logic signed [5:0]      current_trim_o,
    output logic      [3:0]        range_sel_o,
    output logic                   sample_long_enough_o,
    output logic                   edge2_sel_ok_o
);

    localparam int X10_CYC  =
        (`MUC_SAMPLE_X10_NS + `MUC_CLK_PERIOD_NS - 1) / `MUC_CLK_PERIOD_NS;
    localparam int X100_CYC =
        (`MUC_SAMPLE_X100_NS + `MUC_CLK_PERIOD_NS - 1) / `MUC_CLK_PERIOD_NS;
    localparam logic [7:0] X10_CYC_W  = 8'(X10_CYC);
    localparam logic [7:0] X100_CYC_W = 8'(X100_CYC);

    logic [31:0]                   ctrl_r;
    charge_time_pkg::control_fields_t fields;
    charge_time_pkg::edge_state_t  edge_state_r;
    logic [7:0]                    sample_cnt_r;
    logic                          sel_w;

    assign sel_w  = (addr_i == ADDR_W'(`MUC_CONTROL_OFFSET));
    assign fields = '{
        time_generation_enable:  ctrl_r[`MUC_TIME_GEN_BIT],
        edge_gate_enable:        ctrl_r[`MUC_EDGE_GATE_BIT],
        edge_order_enable:       ctrl_r[`MUC_SEQEN_BIT],
        source_discharge_enable: ctrl_r[`MUC_DISCH_BIT],
        trigger_output_enable:   ctrl_r[`MUC_TRIG_BIT],
        current_trim:            ctrl_r[`MUC_TRIM_MSB:`MUC_TRIM_LSB],
        current_range_select:
            charge_time_pkg::current_range_t'(ctrl_r[`MUC_RANGE_MSB:`MUC_RANGE_LSB])
    };

    // control register; bits 31:16 stay zero, including the second-edge select bits 19:16
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= `MUC_RESET_VALUE;
        end else if (wr_i && sel_w) begin
            ctrl_r <= wdata_i & `MUC_WRITE_MASK;
        end
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i && sel_w) begin
            rdata_o <= ctrl_r;
        end else if (rd_i && addr_i == ADDR_W'(`MUC_STATUS_OFFSET)) begin
            rdata_o <= {28'h0000000, edge2_sel_ok_o, sample_long_enough_o,
                        edge_state_r == charge_time_pkg::EDGE_BOTH,
                        edge_state_r != charge_time_pkg::EDGE_IDLE};
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // edge ordering; a gate drop clears any half-seen sequence
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            edge_state_r <= charge_time_pkg::EDGE_IDLE;
            edge1_o      <= 1'b0;
            edge2_o      <= 1'b0;
        end else if (!fields.edge_gate_enable) begin
            edge_state_r <= charge_time_pkg::EDGE_IDLE;
            edge1_o      <= 1'b0;
            edge2_o      <= 1'b0;
        end else begin
            edge1_o <= edge1_i;
            edge2_o <= edge2_i && (!fields.edge_order_enable
                       || edge_state_r != charge_time_pkg::EDGE_IDLE);
            case (edge_state_r)
                charge_time_pkg::EDGE_IDLE: begin
                    if (edge1_i) begin
                        edge_state_r <= charge_time_pkg::EDGE_FIRST;
                    end
                end
                charge_time_pkg::EDGE_FIRST: begin
                    if (edge2_i) begin
                        edge_state_r <= charge_time_pkg::EDGE_BOTH;
                    end
                end
                charge_time_pkg::EDGE_BOTH: begin
                    edge_state_r <= edge_state_r;
                end
                default: begin
                    edge_state_r <= charge_time_pkg::EDGE_IDLE;
                end
            endcase
        end
    end

    // static decodes registered so outputs come from flops
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            delay_gen_en_o  <= 1'b0;
            source_ground_o <= 1'b0;
            trigger_o       <= 1'b0;
            current_trim_o  <= 6'sh00;
            range_sel_o     <= 4'h0;
            edge2_sel_ok_o  <= 1'b0;
        end else begin
            delay_gen_en_o  <= fields.time_generation_enable;
            source_ground_o <= fields.source_discharge_enable;
            trigger_o       <= fields.trigger_output_enable;
            current_trim_o  <= fields.current_trim;
            // status only: warns software when delay mode lacks comparator select
            edge2_sel_ok_o  <= !fields.time_generation_enable
                || ctrl_r[`MUC_EDGE2_SEL_MSB:`MUC_EDGE2_SEL_LSB]
                   == `MUC_EDGE2_SEL_COMP1;
            case (fields.current_range_select)
                charge_time_pkg::RANGE_X1:    range_sel_o <= 4'h1;
                charge_time_pkg::RANGE_X10:   range_sel_o <= 4'h2;
                charge_time_pkg::RANGE_X100:  range_sel_o <= 4'h4;
                charge_time_pkg::RANGE_X1000: range_sel_o <= 4'h8;
                default:                      range_sel_o <= 4'h0;
            endcase
        end
    end

    // sampling time meter; software polls the flag, nothing is blocked
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sample_cnt_r         <= 8'h00;
            sample_long_enough_o <= 1'b0;
        end else if (!sample_active_i) begin
            sample_cnt_r         <= 8'h00;
            sample_long_enough_o <= 1'b0;
        end else begin
            if (sample_cnt_r != 8'hff) begin
                sample_cnt_r <= sample_cnt_r + 8'h01;
            end
            case (fields.current_range_select)
                charge_time_pkg::RANGE_X10:
                    // no sum here: it would wrap once the counter saturates
                    sample_long_enough_o <= sample_cnt_r >= (X10_CYC_W - 8'h01);
                charge_time_pkg::RANGE_X100:
                    sample_long_enough_o <= sample_cnt_r >= (X100_CYC_W - 8'h01);
                default:
                    sample_long_enough_o <= 1'b1;
            endcase
        end
    end

endmodule // charge_time_edge_control

`default_nettype wire

// File: edge_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module edge_control_asserts (
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    input  wire logic [7:0]         addr_i,
    input  wire logic [31:0]        wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic [31:0]        rdata_o,
    input  wire logic               edge1_i,
    input  wire logic               edge1_o,
    input  wire logic               edge2_o,
    input  wire logic               delay_gen_en_o,
    input  wire logic               source_ground_o,
    input  wire logic               trigger_o,
    input  wire logic signed [5:0]  current_trim_o,
    input  wire logic [3:0]         range_sel_o
);
    logic ctrl_wr;
    logic gate_r;
    logic order_r;
    logic seen_r;
    assign ctrl_wr = wr_i && addr_i == 8'h00;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // shadow of gate and order bits, so edge checks need no register read
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gate_r <= 1'b0;
            order_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                gate_r <= wdata_i[11];
                order_r <= wdata_i[10];
            end
            seen_r <= gate_r && (seen_r || edge1_o);
        end
    end
    sequence ctrl_write_s;
        ctrl_wr ##2 1'b1;
    endsequence
    a_delay_gen_follow: assert property (ctrl_write_s |-> delay_gen_en_o == $past(wdata_i[12], 2))
        else $error("delay enable mismatch");
    a_ground_trig: assert property (ctrl_write_s |-> {source_ground_o, trigger_o} == $past(wdata_i[9:8], 2))
        else $error("ground or trigger mismatch");
    a_trim_follow: assert property (ctrl_write_s |-> current_trim_o == $past(wdata_i[7:2], 2))
        else $error("trim mismatch");
    a_range_decode: assert property (ctrl_write_s |-> range_sel_o == 4'h1 << ($past(wdata_i[1:0], 2) - 2'h1))
        else $error("range decode mismatch");
    a_edge_blocked: assert property (!gate_r && !$past(gate_r) |-> !edge1_o && !edge2_o)
        else $error("edge passed while gated");
    a_edge1_pass: assert property (gate_r && $past(gate_r) |-> edge1_o == $past(edge1_i))
        else $error("edge not passed");
    a_edge_order: assert property (edge2_o && order_r && $past(order_r) |-> seen_r)
        else $error("second edge before first");
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read cycle");
endmodule // edge_control_asserts
bind charge_time_edge_control edge_control_asserts chk (.clock_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .edge1_i, .edge1_o, .edge2_o, .delay_gen_en_o, .source_ground_o,
    .trigger_o, .current_trim_o, .range_sel_o);
`default_nettype wire

// File: edge_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module edge_source_model (
    input  wire logic       clock_i,
    input  wire logic [1:0] edge_req_i,
    input  wire logic [7:0] sample_len_i,
    output logic            edge1_o,
    output logic            edge2_o,
    output logic            sample_o
);
    logic [7:0] left_r = 8'h00;
    assign {edge2_o, edge1_o} = edge_req_i;
    // converter holds sampling for the whole requested span; no self discharge
    always_ff @(posedge clock_i) begin
        if (sample_len_i != 8'h00) left_r <= sample_len_i;
        else if (left_r != 8'h00) left_r <= left_r - 8'h01;
    end
    assign sample_o = left_r != 8'h00;
endmodule // edge_source_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic              clock_i, rst_i, wr_i, rd_i, rd_d, e1, e2, samp, e1o, e2o;
    logic              dly, gnd, trg, slong, selok;
    logic [7:0]        addr_i, slen;
    logic [31:0]       wdata_i, rdata_o, w;
    logic [1:0]        ereq;
    logic signed [5:0] trim;
    logic [3:0]        rsel;
    logic [31:0]       exp_q[$];
    int                err_count, n_compared;
    charge_time_edge_control uut (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .edge1_i(e1), .edge2_i(e2), .sample_active_i(samp), .edge1_o(e1o), .edge2_o(e2o),
        .delay_gen_en_o(dly), .source_ground_o(gnd), .trigger_o(trg), .current_trim_o(trim),
        .range_sel_o(rsel), .sample_long_enough_o(slong), .edge2_sel_ok_o(selok));
    edge_source_model far (.clock_i, .edge_req_i(ereq), .sample_len_i(slen), .edge1_o(e1),
        .edge2_o(e2), .sample_o(samp));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task finish_test;
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1; rd_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        addr_i <= a; rd_i <= 1'b1; wr_i <= 1'b0;
        exp_q.push_back(e);
    endtask
    task idle(input int n);
        repeat (n) begin
            @(posedge clock_i);
            wr_i <= 1'b0; rd_i <= 1'b0;
        end
    endtask
    task ed(input logic [1:0] r, input logic [1:0] e);
        @(posedge clock_i);
        ereq <= r;
        repeat (3) @(posedge clock_i);
        chk({e2o, e1o}, e);
    endtask
    always @(posedge clock_i) begin
        if (rd_d) chk(rdata_o, exp_q.pop_front());
        rd_d <= rd_i;
    end
    initial begin
        #60000;
        err_count++;
        finish_test;
    end
    initial begin
        rst_i = 1'b1;
        {wr_i, rd_i, rd_d, addr_i, wdata_i, ereq, slen} = '0;
        err_count = 0;
        n_compared = 0;
        void'($urandom(32'h7110d572));
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        idle(2);
        chk({dly, rsel}, 5'h08);
        rd(8'h00, 32'h0);
        for (int i = 0; i < 8; i++) begin
            w = $urandom & 32'h1ffc | i[1:0];
            if (w[12]) w[19:16] = 4'hd;
            wr(8'h00, w);
            rd(8'h00, w & 32'hffff);
            rd(8'h08, 32'h0);
            idle(3);
            chk({dly, gnd, trg, trim}, {w[12], w[9:2]});
            chk(rsel, 4'h1 << (w[1:0] - 2'h1));
            chk(selok, !w[12]);
        end
        wr(8'h00, 32'h0c00);
        idle(2);
        ed(2'b10, 2'b00);
        ed(2'b11, 2'b11);
        wr(8'h00, 32'h0);
        idle(2);
        ed(2'b11, 2'b00);
        wr(8'h00, 32'h0800);
        idle(2);
        ed(2'b10, 2'b10);
        rd(8'h04, 32'h0000_000b);
        idle(2);
        for (int j = 0; j < 2; j++) begin
            wr(8'h00, 32'h2 | j);
            idle(2);
            slen <= 8'd40;
            @(posedge clock_i);
            slen <= 8'h00;
            repeat (35) @(posedge clock_i);
            chk(slong, j);
            idle(10);
        end
        idle(2);
        finish_test;
    end
endmodule // tb
`default_nettype wire
